//--- inc/mcuie_pkg.sv
// Function
// [RULE1] Add, and, compare, subtract take accumulator plus memory or immediate operand
// [RULE2] Zero, subtract-one and add-one work on any of 256 data addresses
// [RULE3] Invert, rotate and shift work on the accumulator only
// [RULE4] Arithmetic takes 4 cycles; add-one/subtract-one keep carry, others set both; zero to memory keeps both flags here
// [RULE5] Short branches test carry or zero, one byte, 2 cycles
// [RULE6] Short branch target spans -15 to +16 from the branch
// [RULE7] Bit branches test a data bit, displacement spans -126 to +129
// [RULE8] Bit branches are three bytes, 5 cycles, branch on bit 0 or 1
// [RULE9] Bit branches copy the tested bit into carry always
// [RULE10] Bit set/clear pick bit by 3-bit number, 2 bytes, 4 cycles, flags kept
// [RULE11] Software avoids bit set/clear on port and partly read/write-only registers
// [RULE12] With watchdog selected, stop acts as wait
// [RULE13] Control ops are one byte, 2 cycles; only interrupt exit changes flags
// [RULE14] Long jump and call use 12-bit target, 2 bytes, 4 cycles, flags kept
// [RULE15] X, Y, V, W sit at data 80h-83h; X, Y are pointers
// [RULE16] Return stack holds six 12-bit entries
// [RULE17] Call pushes next address; returns pop it into the program counter
// [RULE18] Compare sets flags like subtract but keeps the accumulator
package mcuie_pkg;
  localparam logic [7:0]  ADDR_X       = 8'h80;
  localparam logic [7:0]  ADDR_Y       = 8'h81;
  localparam logic [7:0]  ADDR_SD_BASE = 8'h80;
  localparam int          STACK_DEPTH  = 6;
  localparam logic [2:0]  SP_RESET     = 3'h0;
  localparam logic [2:0]  SP_FULL      = 3'h6;
  localparam logic [11:0] PC_RESET     = 12'h000;
  localparam logic [7:0]  ACC_RESET    = 8'h00;
  // Index of the last cycle of each instruction group (cycles minus one)
  localparam logic [2:0]  LAST_2CYC    = 3'h1;
  localparam logic [2:0]  LAST_4CYC    = 3'h3;
  localparam logic [2:0]  LAST_5CYC    = 3'h4;
  // Opcode groups by upper nibble; bit 7 set marks a short branch
  localparam logic [3:0]  GRP_JUMP     = 4'h0;
  localparam logic [3:0]  GRP_CALL     = 4'h1;
  localparam logic [3:0]  GRP_BITMOD   = 4'h2;
  localparam logic [3:0]  GRP_BITBR    = 4'h3;
  localparam logic [3:0]  GRP_ALU      = 4'h4;
  localparam logic [3:0]  GRP_UNARY    = 4'h5;
  localparam logic [3:0]  GRP_SHORT    = 4'h6;
  localparam logic [3:0]  GRP_INHERENT = 4'h7;
  // Operand modes in bits 1:0 of accumulator and unary groups
  localparam logic [1:0]  MODE_IND_X   = 2'h0;
  localparam logic [1:0]  MODE_IND_Y   = 2'h1;
  localparam logic [1:0]  MODE_DIRECT  = 2'h2;
  localparam logic [1:0]  MODE_IMM_ACC = 2'h3;
  // Accumulator operations, bits 3:2
  localparam logic [1:0]  ALU_ADD      = 2'h0;
  localparam logic [1:0]  ALU_AND      = 2'h1;
  localparam logic [1:0]  ALU_CMP      = 2'h2;
  localparam logic [1:0]  ALU_SUB      = 2'h3;
  // Unary operations, bits 3:2
  localparam logic [1:0]  UN_ZERO      = 2'h0;
  localparam logic [1:0]  UN_MINUS_ONE = 2'h1;
  localparam logic [1:0]  UN_INC       = 2'h2;
  // Inherent operations, bits 2:0
  localparam logic [2:0]  INH_INVERT   = 3'h0;
  localparam logic [2:0]  INH_ROTATE   = 3'h1;
  localparam logic [2:0]  INH_SHIFT    = 3'h2;
  localparam logic [2:0]  INH_NOP      = 3'h3;
  localparam logic [2:0]  INH_SUB_EXIT = 3'h4;
  localparam logic [2:0]  INH_INT_EXIT = 3'h5;
  localparam logic [2:0]  INH_STOP     = 3'h6;
  localparam logic [2:0]  INH_WAIT     = 3'h7;
  // Short branch conditions, bits 6:5
  localparam logic [1:0]  BR_CARRY     = 2'h0;
  localparam logic [1:0]  BR_NO_CARRY  = 2'h1;
  localparam logic [1:0]  BR_ZERO      = 2'h2;
  localparam logic [1:0]  BR_NONZERO   = 2'h3;

  typedef enum logic [1:0] {MCUIE_RUN, MCUIE_WAIT, MCUIE_STOP} mcuie_run_e;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       we;
    logic       re;
  } mcuie_dreq_s;

  typedef struct packed {
    logic [11:0] pc;
    logic [7:0]  acc;
    logic        zero;
    logic        carry;
    logic        in_int;
  } mcuie_stat_s;
endpackage

//--- core/mcuie_core.sv
`timescale 1ns/1ns
module mcuie_core (
  input  wire logic               clk_in,
  input  wire logic               reset_in,
  output logic [11:0]             prog_addr_out,
  input  wire logic [7:0]         prog_data_in,
  output mcuie_pkg::mcuie_dreq_s  dreq_out,
  input  wire logic [7:0]         data_rdata_in,
  input  wire logic               int_req_in,
  input  wire logic [11:0]        int_vector_in,
  output logic                    int_ack_out,
  input  wire logic               watchdog_sel_in,
  output logic                    stop_out,
  output logic                    wait_out,
  output mcuie_pkg::mcuie_stat_s  stat_out
);
  import mcuie_pkg::*;

  logic [11:0] pc_r,  pc_nxt;
  logic [2:0]  cyc_r, cyc_nxt;
  logic [7:0]  op_r,  op_nxt;
  logic [7:0]  op1_r, op1_nxt;
  logic [7:0]  op2_r, op2_nxt;
  logic [7:0]  opnd_r, opnd_nxt;
  logic [7:0]  acc_r, acc_nxt;
  logic        zf_r,  zf_nxt;
  logic        cf_r,  cf_nxt;
  logic        sav_z_r, sav_z_nxt;
  logic        sav_c_r, sav_c_nxt;
  logic        int_r, int_nxt;
  logic [2:0]  sp_r,  sp_nxt;
  logic [11:0] stk_r   [STACK_DEPTH];
  logic [11:0] stk_nxt [STACK_DEPTH];
  mcuie_run_e  run_r, run_nxt;
  logic        wd_s1_r, wd_s2_r;
  logic [2:0]  last_cyc;
  logic [3:0]  grp;

  assign grp = op_r[7:4];

  // Last cycle index of the instruction held in op_r
  always_comb begin
    last_cyc = LAST_4CYC;
    if (op_r[7]) begin
      last_cyc = LAST_2CYC; // [RULE5]
    end else if (grp == GRP_BITBR) begin
      last_cyc = LAST_5CYC; // [RULE8]
    end else if (grp == GRP_INHERENT && op_r[2:0] > INH_SHIFT) begin
      last_cyc = LAST_2CYC; // [RULE13]
    end
  end

  // Main sequencer: fetch, operand gather and execute, one pass per instruction
  always_comb begin
    logic [8:0]  sum9;
    logic [8:0]  dif9;
    logic [7:0]  result;
    logic [7:0]  val;
    logic [2:0]  top;
    logic        take;
    sum9 = 9'h000;
    dif9 = 9'h000;
    result = 8'h00;
    val  = 8'h00;
    top  = (sp_r == SP_RESET) ? SP_RESET : sp_r - 3'h1;
    take = 1'b0;
    pc_nxt    = pc_r;
    cyc_nxt   = cyc_r;
    op_nxt    = op_r;
    op1_nxt   = op1_r;
    op2_nxt   = op2_r;
    opnd_nxt  = opnd_r;
    acc_nxt   = acc_r;
    zf_nxt    = zf_r;
    cf_nxt    = cf_r;
    sav_z_nxt = sav_z_r;
    sav_c_nxt = sav_c_r;
    int_nxt   = int_r;
    sp_nxt    = sp_r;
    stk_nxt   = stk_r;
    run_nxt   = run_r;
    int_ack_out   = 1'b0;
    prog_addr_out = pc_r;
    dreq_out      = '0;
    if (run_r != MCUIE_RUN) begin
      // Any interrupt request ends wait or stop
      if (int_req_in) begin
        run_nxt = MCUIE_RUN;
      end
    end else if (cyc_r == 3'h0) begin
      if (int_req_in && !int_r) begin
        // Interrupt entry at an instruction boundary
        stk_nxt[sp_r == SP_FULL ? top : sp_r] = pc_r; // [RULE16]
        if (sp_r != SP_FULL) begin
          sp_nxt = sp_r + 3'h1;
        end
        sav_z_nxt   = zf_r;
        sav_c_nxt   = cf_r;
        int_nxt     = 1'b1;
        pc_nxt      = int_vector_in;
        int_ack_out = 1'b1;
      end else begin
        op_nxt  = prog_data_in;
        pc_nxt  = pc_r + 12'h001;
        cyc_nxt = 3'h1;
      end
    end else begin
      cyc_nxt = (cyc_r == last_cyc) ? 3'h0 : cyc_r + 3'h1;
      if (op_r[7]) begin
        case (op_r[6:5]) // [RULE5]
          BR_CARRY:    take = cf_r;
          BR_NO_CARRY: take = !cf_r;
          BR_ZERO:     take = zf_r;
          default:     take = !zf_r;
        endcase
        if (take) begin
          // Forward adds 1..16 to the branch address, backward subtracts 0..15
          pc_nxt = op_r[4] ? pc_r - 12'h001 - {8'h00, op_r[3:0]}
                           : pc_r + {8'h00, op_r[3:0]}; // [RULE6]
        end
      end else begin
        case (grp)
          GRP_JUMP, GRP_CALL: begin
            if (cyc_r == 3'h1) begin
              op1_nxt = prog_data_in;
              pc_nxt  = pc_r + 12'h001; // [RULE14]
            end else if (cyc_r == last_cyc) begin
              if (grp == GRP_CALL) begin
                // A full stack keeps its depth; the newest entry is overwritten
                stk_nxt[sp_r == SP_FULL ? top : sp_r] = pc_r; // [RULE17]
                if (sp_r != SP_FULL) begin
                  sp_nxt = sp_r + 3'h1;
                end
              end
              pc_nxt = {op_r[3:0], op1_r}; // [RULE14]
            end
          end
          GRP_BITMOD, GRP_BITBR: begin
            if (cyc_r == 3'h1) begin
              op1_nxt = prog_data_in;
              pc_nxt  = pc_r + 12'h001;
            end else if (grp == GRP_BITBR && cyc_r == 3'h2) begin
              op2_nxt = prog_data_in;
              pc_nxt  = pc_r + 12'h001; // [RULE8]
            end else if (cyc_r == last_cyc - 3'h1) begin
              dreq_out.addr = op1_r;
              dreq_out.re   = 1'b1;
              opnd_nxt      = data_rdata_in;
            end else if (cyc_r == last_cyc) begin
              if (grp == GRP_BITMOD) begin
                result = opnd_r;
                result[op_r[2:0]] = !op_r[3]; // [RULE10]
                dreq_out.addr  = op1_r;
                dreq_out.wdata = result;
                dreq_out.we    = 1'b1;
              end else begin
                cf_nxt = opnd_r[op_r[2:0]]; // [RULE9]
                if (opnd_r[op_r[2:0]] == op_r[3]) begin
                  // Target is the branch address plus 2 plus the signed byte
                  pc_nxt = pc_r - 12'h001 + {{4{op2_r[7]}}, op2_r}; // [RULE7]
                end
              end
            end
          end
          GRP_ALU, GRP_UNARY, GRP_SHORT: begin
            if (cyc_r == 3'h1) begin
              if (grp == GRP_SHORT) begin
                op1_nxt = ADDR_SD_BASE + {6'h00, op_r[1:0]}; // [RULE15]
              end else if (op_r[1:0] == MODE_DIRECT ||
                           (grp == GRP_ALU && op_r[1:0] == MODE_IMM_ACC)) begin
                op1_nxt = prog_data_in;
                pc_nxt  = pc_r + 12'h001;
              end else if (op_r[1:0] != MODE_IMM_ACC) begin
                dreq_out.addr = op_r[0] ? ADDR_Y : ADDR_X; // [RULE15]
                dreq_out.re   = 1'b1;
                op1_nxt       = data_rdata_in;
              end
            end else if (cyc_r == 3'h2) begin
              if (op_r[1:0] == MODE_IMM_ACC && grp != GRP_SHORT) begin
                opnd_nxt = (grp == GRP_ALU) ? op1_r : acc_r; // [RULE1]
              end else begin
                dreq_out.addr = op1_r; // [RULE2]
                dreq_out.re   = 1'b1;
                opnd_nxt      = data_rdata_in;
              end
            end else if (cyc_r == last_cyc) begin
              if (grp == GRP_ALU) begin
                sum9 = {1'b0, acc_r} + {1'b0, opnd_r};
                dif9 = {1'b0, acc_r} - {1'b0, opnd_r};
                case (op_r[3:2]) // [RULE1]
                  ALU_ADD: begin
                    result = sum9[7:0];
                    cf_nxt = sum9[8];
                  end
                  ALU_AND: begin
                    result = acc_r & opnd_r;
                    cf_nxt = 1'b0;
                  end
                  default: begin
                    result = dif9[7:0];
                    cf_nxt = dif9[8];
                  end
                endcase
                zf_nxt = (result == 8'h00); // [RULE4]
                if (op_r[3:2] != ALU_CMP) begin
                  acc_nxt = result; // [RULE18]
                end
              end else begin
                val = opnd_r;
                case (op_r[3:2])
                  UN_MINUS_ONE: result = val - 8'h01;
                  UN_INC:       result = val + 8'h01;
                  default:      result = 8'h00;
                endcase
                if (op_r[3:2] != UN_ZERO) begin
                  zf_nxt = (result == 8'h00); // [RULE4]
                end
                if (grp == GRP_UNARY && op_r[1:0] == MODE_IMM_ACC) begin
                  acc_nxt = result;
                  if (op_r[3:2] == UN_ZERO) begin
                    zf_nxt = 1'b1;
                    cf_nxt = 1'b0;
                  end
                end else begin
                  dreq_out.addr  = op1_r; // [RULE2]
                  dreq_out.wdata = result;
                  dreq_out.we    = 1'b1;
                end
              end
            end
          end
          default: begin
            if (cyc_r == last_cyc) begin
              case (op_r[2:0])
                INH_INVERT: begin
                  acc_nxt = ~acc_r; // [RULE3]
                  cf_nxt  = acc_r[7];
                  zf_nxt  = (acc_r == 8'hff); // [RULE4]
                end
                INH_ROTATE: begin
                  acc_nxt = {acc_r[6:0], cf_r}; // [RULE3]
                  cf_nxt  = acc_r[7];
                  zf_nxt  = ({acc_r[6:0], cf_r} == 8'h00); // [RULE4]
                end
                INH_SHIFT: begin
                  acc_nxt = {acc_r[6:0], 1'b0}; // [RULE3]
                  cf_nxt  = acc_r[7];
                  zf_nxt  = (acc_r[6:0] == 7'h00); // [RULE4]
                end
                INH_SUB_EXIT, INH_INT_EXIT: begin
                  pc_nxt = stk_r[top]; // [RULE17]
                  sp_nxt = top;
                  if (op_r[2:0] == INH_INT_EXIT) begin
                    zf_nxt  = sav_z_r; // [RULE13]
                    cf_nxt  = sav_c_r;
                    int_nxt = 1'b0;
                  end
                end
                INH_STOP: begin
                  // Watchdog running forbids stopping the oscillator
                  run_nxt = wd_s2_r ? MCUIE_WAIT : MCUIE_STOP; // [RULE12]
                end
                INH_WAIT: begin
                  run_nxt = MCUIE_WAIT; // [RULE13]
                end
                default: begin
                end
              endcase
            end
          end
        endcase
      end
    end
  end

  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      pc_r    <= PC_RESET;
      cyc_r   <= 3'h0;
      op_r    <= 8'h00;
      op1_r   <= 8'h00;
      op2_r   <= 8'h00;
      opnd_r  <= 8'h00;
      acc_r   <= ACC_RESET;
      zf_r    <= 1'b0;
      cf_r    <= 1'b0;
      sav_z_r <= 1'b0;
      sav_c_r <= 1'b0;
      int_r   <= 1'b0;
      sp_r    <= SP_RESET;
      run_r   <= MCUIE_RUN;
      wd_s1_r <= 1'b0;
      wd_s2_r <= 1'b0;
      for (int i = 0; i < STACK_DEPTH; i++) begin
        stk_r[i] <= 12'h000;
      end
    end else begin
      pc_r    <= pc_nxt;
      cyc_r   <= cyc_nxt;
      op_r    <= op_nxt;
      op1_r   <= op1_nxt;
      op2_r   <= op2_nxt;
      opnd_r  <= opnd_nxt;
      acc_r   <= acc_nxt;
      zf_r    <= zf_nxt;
      cf_r    <= cf_nxt;
      sav_z_r <= sav_z_nxt;
      sav_c_r <= sav_c_nxt;
      int_r   <= int_nxt;
      sp_r    <= sp_nxt;
      run_r   <= run_nxt;
      wd_s1_r <= watchdog_sel_in;
      wd_s2_r <= wd_s1_r;
      stk_r   <= stk_nxt;
    end
  end

  assign stop_out = (run_r == MCUIE_STOP);
  assign wait_out = (run_r == MCUIE_WAIT);
  assign stat_out = '{pc: pc_r, acc: acc_r, zero: zf_r, carry: cf_r, in_int: int_r};
endmodule // mcuie_core

//--- sim/mcuie_core_checker.sv
`timescale 1ns/1ns
module mcuie_core_checker (
  input wire logic                   clk_in,
  input wire logic                   reset_in,
  input wire mcuie_pkg::mcuie_dreq_s dreq_out,
  input wire logic                   int_req_in,
  input wire logic [11:0]            int_vector_in,
  input wire logic                   int_ack_out,
  input wire logic                   watchdog_sel_in,
  input wire logic                   stop_out,
  input wire logic                   wait_out,
  input wire mcuie_pkg::mcuie_stat_s stat_out
);
  import mcuie_pkg::*;
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (reset_in);
  sequence s_parked;
    (stop_out || wait_out) && !int_req_in;
  endsequence
  sequence s_wake;
    (stop_out || wait_out) && int_req_in;
  endsequence
  a_wake_up: assert property (s_wake |=> !stop_out && !wait_out)
    else $error("core stayed parked with a request");
  a_parked_still: assert property (s_parked |=> $stable(stat_out.pc) &&
                                   $stable(stat_out.acc))
    else $error("parked core changed state");
  a_mode_excl: assert property (!(stop_out && wait_out))
    else $error("stop and wait both high");
  // Six samples leave room for the two-stage synchroniser on the option pin
  a_stop_masked: assert property (watchdog_sel_in [*6] |-> !$rose(stop_out))
    else $error("stop entered with watchdog selected");
  a_ack_vector: assert property (int_ack_out |=> stat_out.pc == $past(int_vector_in))
    else $error("entry did not load vector");
  a_ack_enter: assert property (int_ack_out |=> stat_out.in_int)
    else $error("entry did not mark interrupt");
  a_no_nest: assert property (stat_out.in_int |-> !int_ack_out)
    else $error("nested interrupt accepted");
  a_rmw_addr: assert property (dreq_out.we |-> $past(dreq_out.re) &&
                               $past(dreq_out.addr) == dreq_out.addr)
    else $error("write not preceded by read of same byte");
  a_write_flags: assert property (dreq_out.we |=> $stable(stat_out.carry) &&
                                  $stable(stat_out.acc))
    else $error("memory write disturbed carry or accumulator");
endmodule // mcuie_core_checker

bind mcuie_core mcuie_core_checker chk_u (
  .clk_in(clk_in), .reset_in(reset_in), .dreq_out(dreq_out), .int_req_in(int_req_in),
  .int_vector_in(int_vector_in), .int_ack_out(int_ack_out),
  .watchdog_sel_in(watchdog_sel_in), .stop_out(stop_out), .wait_out(wait_out),
  .stat_out(stat_out)
);

//--- sim/mcu_core_instruction_execution_tb.sv
`timescale 1ns/1ns
module mcu_core_instruction_execution_tb;
  import mcuie_pkg::*;
  typedef struct {
    logic [7:0] acc;
    logic       z;
    logic       c;
    int         cyc;
    logic [7:0] ma;
    logic [7:0] mv;
  } mcuie_note_s;
  logic        clk_in, reset_in, int_req_in, watchdog_sel_in, int_ack_out, stop_out, wait_out;
  logic [11:0] prog_addr_out, int_vector_in;
  logic [7:0]  prog_data_in, data_rdata_in;
  mcuie_dreq_s dreq_out;
  mcuie_stat_s stat_out;
  logic [7:0]  rom [0:4095];
  logic [7:0]  dmem [0:255];
  mcuie_note_s q [$];
  mcuie_note_s e, n;
  int          fails, n_checks, cnt, armed;
  logic [31:0] seed;

  mcuie_core dut_u (
    .clk_in(clk_in), .reset_in(reset_in), .prog_addr_out(prog_addr_out),
    .prog_data_in(prog_data_in), .dreq_out(dreq_out), .data_rdata_in(data_rdata_in),
    .int_req_in(int_req_in), .int_vector_in(int_vector_in), .int_ack_out(int_ack_out),
    .watchdog_sel_in(watchdog_sel_in), .stop_out(stop_out), .wait_out(wait_out),
    .stat_out(stat_out)
  );

  function automatic logic [7:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction

  initial begin
    clk_in = 1'b0;
    forever #25 clk_in = ~clk_in;
  end
  // Cycle index since reset release; cycle 0 is the first fetch
  always @(posedge clk_in or posedge reset_in) begin
    if (reset_in) cnt <= 0;
    else cnt <= cnt + 1;
  end
  // Memories answer in the second half of the cycle, as an async ROM would
  always @(negedge clk_in) begin
    prog_data_in <= rom[prog_addr_out];
    data_rdata_in <= dmem[dreq_out.addr];
  end
  always @(posedge clk_in) begin
    if (dreq_out.we === 1'b1) dmem[dreq_out.addr] <= dreq_out.wdata;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Every program ends in a self loop at ff0; reaching it is the result
  always @(negedge clk_in) begin
    if (armed && prog_addr_out === 12'hff0) begin
      n = q.pop_front();
      armed = 0;
      chk(stat_out.acc, n.acc);
      chk({stat_out.zero, stat_out.carry}, {n.z, n.c});
      if (n.cyc >= 0) chk(cnt, n.cyc);
      chk(dmem[n.ma], n.mv);
    end
  end

  task automatic put(input int a, input logic [7:0] b0, input logic [7:0] b1);
    rom[a] = b0;
    rom[a + 1] = b1;
  endtask

  // Unused space holds no-ops, so a wrong path shows up as a wrong cycle count
  task automatic clear();
    foreach (rom[i]) rom[i] = 8'h73;
    foreach (dmem[i]) dmem[i] = 8'h00;
    put(12'hff0, 8'h0f, 8'hf0);
    e = '{8'h00, 1'b0, 1'b0, 0, 8'h00, 8'h00};
  endtask

  task automatic start();
    q.push_back(e);
    @(negedge clk_in);
    reset_in = 1'b1;
    repeat (6) @(negedge clk_in);
    reset_in = 1'b0;
    armed = 1;
  endtask

  task automatic finish();
    int k;
    k = 0;
    while (armed && k < 6000) begin
      @(negedge clk_in);
      k++;
    end
    if (armed) begin
      fails++;
      armed = 0;
      q.delete();
    end
  endtask

  task automatic go();
    start();
    finish();
  endtask

  task automatic wrap_up();
    $display("checks=%0d fails=%0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  initial begin
    repeat (60000) @(posedge clk_in);
    fails++;
    wrap_up();
  end

  initial begin
    reset_in = 1'b1;
    int_req_in = 1'b0;
    int_vector_in = 12'hff0;
    watchdog_sel_in = 1'b0;
    seed = 32'd67204;
    fails = 0;
    n_checks = 0;
    armed = 0;
    for (int k = 0; k < 8; k++) begin
      logic [7:0] r1, r2;
      logic [8:0] s;
      clear();
      r1 = rnd();
      r2 = (k < 4) ? rnd() : r1;
      put(0, 8'h43, r1);
      put(2, {4'h4, k[1:0], 2'h3}, r2);
      put(4, 8'h0f, 8'hf0);
      s = {1'b0, r1} + {1'b0, r2};
      e.acc = k[1:0] == ALU_ADD ? s[7:0] : k[1:0] == ALU_AND ? r1 & r2 :
              k[1:0] == ALU_CMP ? r1 : r1 - r2;
      e.c = k[1:0] == ALU_ADD ? s[8] : k[1:0] == ALU_AND ? 1'b0 : r1 < r2;
      e.z = k[1:0] == ALU_CMP ? r1 == r2 : e.acc == 8'h00;
      e.cyc = 12;
      go();
    end
    for (int k = 0; k < 2; k++) begin
      logic [7:0] p, v1, v2;
      clear();
      p = rnd() & 8'h7f;
      v1 = rnd();
      v2 = rnd();
      dmem[8'h80 + k] = p;
      dmem[p] = v1;
      dmem[8'h90] = v2;
      rom[0] = {6'h10, k[1:0]};
      put(1, 8'h42, 8'h90);
      put(3, 8'h0f, 8'hf0);
      e.acc = v1 + v2;
      e.c = ({1'b0, v1} + {1'b0, v2}) > 9'h0ff;
      e.z = e.acc == 8'h00;
      e.cyc = 12;
      e.ma = 8'(8'h80 + k);
      e.mv = p;
      go();
    end
    for (int k = 0; k < 6; k++) begin
      logic [7:0] a, v;
      clear();
      a = (k < 3) ? rnd() : 8'h82;
      v = rnd();
      dmem[a] = v;
      put(0, 8'h43, 8'hff);
      put(2, 8'h43, 8'h01);
      rom[4] = 8'(8'h52 + 8'h10 * (k / 3) + 8'h04 * (k % 3));
      rom[5] = a;
      put(k < 3 ? 6 : 5, 8'h0f, 8'hf0);
      e.mv = (k % 3 == 0) ? 8'h00 : (k % 3 == 1) ? v - 8'h01 : v + 8'h01;
      e.z = (k % 3 == 0) ? 1'b1 : e.mv == 8'h00;
      e.c = 1'b1;
      e.ma = a;
      e.cyc = 16;
      go();
    end
    for (int k = 0; k < 3; k++) begin
      logic [7:0] r;
      clear();
      r = rnd();
      put(0, 8'h43, r);
      put(2, 8'h70, 8'h71);
      rom[4] = 8'h72;
      put(5, 8'h0f, 8'hf0);
      {e.c, e.acc} = {r[7], ~r};
      {e.c, e.acc} = {e.acc, e.c};
      {e.c, e.acc} = {e.acc, 1'b0};
      e.z = e.acc == 8'h00;
      e.cyc = 20;
      go();
    end
    for (int k = 0; k < 8; k++) begin
      clear();
      put(0, 8'h43, 8'hff);
      put(2, 8'h43, {7'h00, k[0]});
      rom[4] = {1'b1, k[2:1], 5'h0f};
      put(5, 8'h0f, 8'hf0);
      rom[8'h14] = 8'h70;
      put(8'h15, 8'h0f, 8'hf0);
      {e.z, e.c, e.acc} = {k[0], k[0], k[0] ? 8'h00 : 8'hff};
      e.cyc = (k[0] ^ k[1]) ? 18 : 14;
      if (k[0] ^ k[1]) {e.c, e.acc, e.z} = {e.acc[7], ~e.acc, e.acc == 8'hff};
      go();
    end
    clear();
    put(0, 8'h00, 8'h1f);
    rom[8'h1f] = 8'hbf;
    put(8'h10, 8'h0f, 8'hf0);
    e.cyc = 10;
    go();
    for (int k = 0; k < 8; k++) begin
      logic [7:0] d, t;
      int tg;
      clear();
      d = rnd();
      t = rnd();
      tg = k[1] ? 12'h082 : 12'h181;
      dmem[8'h40] = d;
      put(0, 8'h01, 8'h00);
      put(12'h100, {4'h3, k[0], t[2:0]}, 8'h40);
      rom[12'h102] = k[1] ? 8'h80 : 8'h7f;
      put(12'h103, 8'h0f, 8'hf0);
      rom[tg] = 8'h73;
      put(tg + 1, 8'h0f, 8'hf0);
      e.c = d[t[2:0]];
      e.cyc = (d[t[2:0]] == k[0]) ? 15 : 13;
      go();
    end
    for (int k = 0; k < 4; k++) begin
      logic [7:0] d, t;
      clear();
      d = rnd();
      t = rnd();
      dmem[8'h40] = d;
      put(0, 8'h43, 8'hff);
      put(2, 8'h43, 8'h01);
      // Target is a plain RAM byte, never a port data register
      put(4, {4'h2, k[0], t[2:0]}, 8'h40);
      put(6, 8'h0f, 8'hf0);
      e = '{8'h00, 1'b1, 1'b1, 16, 8'h40, 8'h00};
      e.mv = k[0] ? d & ~(8'h01 << t[2:0]) : d | (8'h01 << t[2:0]);
      go();
    end
    clear();
    put(0, 8'h1a, 8'hbc);
    rom[12'habc] = 8'h74;
    put(2, 8'h0f, 8'hf0);
    e.cyc = 10;
    go();
    for (int k = 0; k < 2; k++) begin
      clear();
      watchdog_sel_in = k[0];
      rom[3] = 8'h76;
      e.cyc = -1;
      start();
      repeat (14) @(negedge clk_in);
      chk(wait_out, k[0]);
      chk(stop_out, !k[0]);
      int_req_in = 1'b1;
      finish();
      int_req_in = 1'b0;
    end
    // Wait, wake, enter the handler, restore the saved flags on interrupt exit
    clear();
    int_vector_in = 12'h200;
    put(0, 8'h43, 8'h01);
    rom[2] = 8'h77;
    put(3, 8'h0f, 8'hf0);
    put(12'h200, 8'h43, 8'hff);
    rom[12'h202] = 8'h75;
    e.cyc = 22;
    start();
    repeat (10) @(negedge clk_in);
    // Two cycles: one to leave wait, one for the entry at the boundary
    int_req_in = 1'b1;
    repeat (2) @(negedge clk_in);
    int_req_in = 1'b0;
    finish();
    wrap_up();
  end
endmodule // mcu_core_instruction_execution_tb
